// file: meter_defines.svh
/*
  Constants for the meter post-processing block: register indexes, field
  positions, scale constants and timing figures.
  Assumes the includer uses a 250 MHz clock and 32-bit register words.
*/
// What this block does
// - Alarm deadband lies on the inactive side; zero delay asserts at once.
// - Flash select 0 none, 1-4 that setpoint active, 5 any active.
// - Final store commits all edited configuration at once and resumes run mode.
// - Setpoint view steps four setpoints, 15 s each, number then value.
// - Digit shift or increment restarts the current view interval.
// - Reset or view timeout discards a setpoint edit.
// - Setpoint stored only on a second setpoint press while shown.
// - Each reading updates peak if greater, valley if smaller, also in view.
// - Increment shows peak, shift shows valley, only with both view locks clear.
// - Peak or valley view flashes the display and never times out.
// - Setpoint or menu leaves extremes; reset starts a new tracking period.
// - Output enable set drives analog output while the edit bit is clear, else inactive.
// - Calibrated type 0 trims voltage output, 1 trims current output.
// - Calibration applies to exactly one output while driving, to neither while inactive.
// - Readings map to 15-bit output code by a derived scale and offset.
// - Scale and offset form the line through two entered points.
// - Type, points and trims change only while their lock bit is 0.
// - Four trims; the pair of the selected calibrated output applies.
// - Source select: 0 raw, 1 filtered, 2 peak, 3 valley.
// - Alarm asserts after its own count of consecutive readings over limit.
`ifndef METER_DEFINES_SVH
`define METER_DEFINES_SVH
`define NCFG 16
`define R_CTRL 6'h00
`define R_LOCK 6'h01
`define R_ADLY 6'h02
`define R_ADB 6'h03
`define R_SP0 6'h04
`define R_P1R 6'h08
`define R_P1O 6'h09
`define R_P2R 6'h0A
`define R_P2O 6'h0B
`define R_VZ 6'h0C
`define R_VG 6'h0D
`define R_CZ 6'h0E
`define R_CG 6'h0F
`define R_STAT 6'h10
`define R_PEAK 6'h11
`define R_VALLEY 6'h12
`define CTRL_EN 0
`define CTRL_TYPE 1
`define CTRL_EDIT 2
`define CTRL_STORE 3
`define CTRL_FLASH 6:4
`define CTRL_SRC 9:8
`define LK_PEAK 0
`define LK_VALLEY 1
`define LK_TYPE 2
`define LK_SCOF 3
`define LK_TRIM 4
`define ADLY_1 7:0
`define ADLY_2 15:8
`define FL_NONE 3'h0
`define FL_ANY 3'h5
`define SRC_RAW 2'h0
`define SRC_FILT 2'h1
`define SRC_PEAK 2'h2
`define B_SETPT 0
`define B_SHIFT 1
`define B_INC 2
`define B_RESET 3
`define B_MENU 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define LAST_SP 2'h3
`define LEFT_DIGIT 2'h3
`define CLK_HZ 64'd250000000
`define SP_VIEW_SEC 64'd15
`define NUM_SHOW_MS 64'd1000
`define MS_PER_S 64'd1000
`define SCALE_SH 15
`define GAIN_ONE 18'sh08000
`define CODE_MAX 16'h7FFF
`endif

// file: meter_pkg.sv
/*
  Types of the meter post-processing block: view states and state records.
  Assumes meter_defines.svh is on the include path.
*/
`include "meter_defines.svh"
package meter_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_SP_NUM, ST_SP_VAL, ST_PEAK, ST_VALLEY} view_t;
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [`NCFG-1:0][31:0] shd;
    logic [`NCFG-1:0][31:0] act;
    view_t view;
    logic [1:0] idx;
    logic [1:0] dig;
    logic [31:0] tmr;
    logic [15:0] edit;
    logic signed [15:0] peak;
    logic signed [15:0] valley;
    logic newper;
    logic [1:0][7:0] acnt;
    logic [1:0] alarm;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] dval;
    logic flash;
    logic [3:0] spact;
    logic [15:0] acode;
    logic aen;
    logic vcal;
    logic ccal;
  } st_t;
  typedef struct packed {
    logic signed [31:0] scale;
    logic [15:0] code;
  } map_st_t;
endpackage

// file: amap_if.sv
/*
  Carrier between the meter core and its analog mapper.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface amap_if;
  logic signed [15:0] x;
  logic signed [15:0] r1;
  logic signed [15:0] o1;
  logic signed [15:0] r2;
  logic signed [15:0] o2;
  logic signed [15:0] vz;
  logic signed [15:0] vg;
  logic signed [15:0] cz;
  logic signed [15:0] cg;
  logic cal_type;
  logic [15:0] code;
  modport host(output x, r1, o1, r2, o2, vz, vg, cz, cg, cal_type, input code);
  modport mapper(input x, r1, o1, r2, o2, vz, vg, cz, cg, cal_type, output code);
endinterface
`default_nettype wire

// file: analog_map.sv
/*
  Two-point line mapping of a reading to a 15-bit output code, then trim.
  Assumes the host holds the points and trims stable between commits.
*/
`timescale 1ns/1ps
`default_nettype none
`include "meter_defines.svh"
module analog_map
  import meter_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  amap_if.mapper bus
);
  map_st_t r;
  map_st_t n;
  logic signed [31:0] span_r;
  logic signed [31:0] span_o;
  logic signed [48:0] prod;
  logic signed [33:0] lin;
  logic signed [17:0] gain;
  logic signed [15:0] zero;
  logic signed [52:0] trim;

  ////////////////////////////////////////////////////////////////////////
  // Slope is registered so the divider stays off the per-reading path
  always_comb
  begin
    n = r;
    span_r = 32'(bus.r2) - 32'(bus.r1);
    span_o = (32'(bus.o2) - 32'(bus.o1)) <<< `SCALE_SH;
    n.scale = (span_r == 32'sh0) ? 32'sh0 : span_o / span_r;
    prod = 49'(33'(bus.x) - 33'(bus.r1)) * 49'(r.scale);
    lin = 34'(bus.o1) + 34'(prod >>> `SCALE_SH);
    gain = `GAIN_ONE + 18'(bus.cal_type ? bus.cg : bus.vg);
    zero = bus.cal_type ? bus.cz : bus.vz;
    trim = ((53'(lin) * 53'(gain)) >>> `SCALE_SH) + 53'(zero);
    // Clamp to the 15-bit code range
    if (trim[52])
      n.code = 16'h0000;
    else if (trim > $signed(53'(`CODE_MAX)))
      n.code = `CODE_MAX;
    else
      n.code = trim[15:0];
  end

  assign bus.code = r.code;

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end
endmodule
`default_nettype wire

// file: meter_post.sv
/*
  Meter post-processing: alarms, flash, setpoint view, peak/valley and
  analog output configuration behind an AXI4-Lite register slave.
  Assumes readings come from logic on CLK and buttons from pins.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "meter_defines.svh"
module meter_post
  import meter_pkg::*;
#(
  parameter logic [31:0] SP_TIMEOUT_CYCLES = 32'(`SP_VIEW_SEC * `CLK_HZ),
  parameter logic [31:0] NUM_SHOW_CYCLES = 32'(`NUM_SHOW_MS * `CLK_HZ / `MS_PER_S)
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic signed [15:0] RDG_RAW,
  input wire logic signed [15:0] RDG_FILT,
  input wire logic RDG_VALID,
  input wire logic BTN_SETPT,
  input wire logic BTN_SHIFT,
  input wire logic BTN_INC,
  input wire logic BTN_RESET,
  input wire logic BTN_MENU,
  output logic [15:0] DISP_VALUE,
  output logic [2:0] DISP_MODE,
  output logic [1:0] DISP_DIGIT,
  output logic DISP_FLASH,
  output logic [3:0] SP_ACTIVE,
  output logic [15:0] ANALOG_CODE,
  output logic ANALOG_EN,
  output logic VOLT_CAL,
  output logic CURR_CAL
);
  st_t r;
  st_t n;
  logic [4:0] press;
  logic [5:0] wi;
  logic [5:0] ri;
  logic [31:0] wmerge;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_now;
  logic store_now;
  logic [1:0] ovr;
  logic [1:0] clr;
  logic [1:0] ge;
  logic [3:0] cur_act;
  logic [2:0] fsel;
  logic flash_hit;
  logic [31:0] lock;
  logic in_sp;
  amap_if amap();

  ////////////////////////////////////////////////////////////////////////
  // Button presses are stage two rising against stage three; stage one feeds only stage two
  assign press = r.s2 & ~r.s3;
  assign lock = r.shd[`R_LOCK];
  assign in_sp = (r.view == ST_SP_NUM) || (r.view == ST_SP_VAL);
  assign wi = r.awaddr[7:2];
  assign ri = ARADDR[7:2];
  assign wr_now = r.aw_got && r.w_got && !r.bvalid;
  assign store_now = wr_now && (wi == `R_CTRL) && wmerge[`CTRL_STORE];

  // Byte lanes merge the write data over the old word
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign wmerge[8*b +: 8] = r.wstrb[b] ? r.wdata[8*b +: 8] : r.shd[wi[3:0]][8*b +: 8];
    end
  endgenerate

  // Per-alarm and per-setpoint comparisons against the live reading
  genvar a;
  generate
    for (a = 0; a < 2; a++)
    begin : g_cmp
      logic signed [16:0] lvl;
      logic signed [16:0] rel;
      assign lvl = 17'($signed(r.act[`R_SP0 + 2 + a][15:0]));
      assign rel = lvl - $signed({1'b0, r.act[`R_ADB][15:0]});
      assign ovr[a] = 17'(RDG_RAW) > lvl;
      assign clr[a] = 17'(RDG_RAW) < rel;
      assign ge[a] = RDG_RAW >= $signed(r.act[`R_SP0 + a][15:0]);
    end
  endgenerate

  assign cur_act = {r.alarm, ge};
  assign fsel = r.act[`R_CTRL][`CTRL_FLASH];
  assign flash_hit = (fsel == `FL_ANY) ? |cur_act :
                     (fsel != `FL_NONE && fsel < `FL_ANY) ? cur_act[fsel[1:0] - 2'h1] : 1'b0;

  // Read mux; unmapped words answer with an error
  always_comb
  begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (ri < `NCFG)
      rd_word = r.shd[ri[3:0]];
    else if (ri == `R_STAT)
      rd_word = {23'h0, r.newper, cur_act, 1'b0, r.view};
    else if (ri == `R_PEAK)
      rd_word = 32'(r.peak);
    else if (ri == `R_VALLEY)
      rd_word = 32'(r.valley);
    else
      rd_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog mapping source and constants come from the committed copy
  // source select
  assign amap.x = (r.act[`R_CTRL][`CTRL_SRC] == `SRC_RAW) ? RDG_RAW :
                  (r.act[`R_CTRL][`CTRL_SRC] == `SRC_FILT) ? RDG_FILT :
                  (r.act[`R_CTRL][`CTRL_SRC] == `SRC_PEAK) ? r.peak : r.valley;
  assign amap.r1 = r.act[`R_P1R][15:0];
  assign amap.o1 = r.act[`R_P1O][15:0];
  assign amap.r2 = r.act[`R_P2R][15:0];
  assign amap.o2 = r.act[`R_P2O][15:0];
  assign amap.vz = r.act[`R_VZ][15:0];
  assign amap.vg = r.act[`R_VG][15:0];
  assign amap.cz = r.act[`R_CZ][15:0];
  assign amap.cg = r.act[`R_CG][15:0];
  assign amap.cal_type = r.act[`R_CTRL][`CTRL_TYPE];

  analog_map u_map (
    .clk(CLK),
    .rst(RST),
    .bus(amap.mapper)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb
  begin
    logic [31:0] w;
    logic wr_ok;
    w = wmerge;
    wr_ok = 1'b1;
    n = r;
    n.s1 = {BTN_MENU, BTN_RESET, BTN_INC, BTN_SHIFT, BTN_SETPT};
    n.s2 = r.s1;
    n.s3 = r.s2;

    // Write channel: address and data taken in either order
    if (AWVALID && r.awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = AWADDR;
    end
    if (WVALID && r.wready)
    begin
      n.w_got = 1'b1;
      n.wdata = WDATA;
      n.wstrb = WSTRB;
    end
    if (r.bvalid && BREADY)
      n.bvalid = 1'b0;
    if (wr_now)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wi < `NCFG) ? `RESP_OKAY : `RESP_SLVERR;
      if (wi == `R_CTRL)
      begin
        w[`CTRL_STORE] = 1'b0;
        if (lock[`LK_TYPE])
          w[`CTRL_TYPE] = r.shd[`R_CTRL][`CTRL_TYPE];
      end
      if (wi >= `R_P1R && wi <= `R_P2O && lock[`LK_SCOF])
        wr_ok = 1'b0;
      if (wi >= `R_VZ && wi < `NCFG && lock[`LK_TRIM])
        wr_ok = 1'b0;
      if (wi < `NCFG && wr_ok)
        n.shd[wi[3:0]] = w;
      // store puts every edit into effect
      if (store_now)
      begin
        n.act = n.shd;
        n.view = ST_RUN;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // Read channel: one read at a time
    if (r.rvalid && RREADY)
      n.rvalid = 1'b0;
    if (ARVALID && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Peak and valley tracking runs in every view
    if (RDG_VALID)
    begin
      if (r.newper)
      begin
        n.peak = RDG_RAW;
        n.valley = RDG_RAW;
        n.newper = 1'b0;
      end
      else
      begin
        if (RDG_RAW > r.peak)
          n.peak = RDG_RAW;
        if (RDG_RAW < r.valley)
          n.valley = RDG_RAW;
      end
    end

    // Alarms count consecutive readings over the level
    if (RDG_VALID)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (r.alarm[i])
        begin
          if (clr[i])
          begin
            n.alarm[i] = 1'b0;
            n.acnt[i] = 8'h00;
          end
        end
        else if (ovr[i])
        begin
          if (r.acnt[i] >= r.act[`R_ADLY][8*i +: 8])
            n.alarm[i] = 1'b1;
          else
            n.acnt[i] = r.acnt[i] + 8'h01;
        end
        else
          n.acnt[i] = 8'h00;
      end
    end

    // Front-panel view machine
    unique case (r.view)
      ST_RUN:
      begin
        if (press[`B_SETPT])
        begin
          n.view = ST_SP_NUM;
          n.idx = 2'h0;
          n.tmr = 32'h0;
          n.dig = `LEFT_DIGIT;
          n.edit = r.act[`R_SP0][15:0];
        end
        else if (press[`B_INC] && !lock[`LK_PEAK] && !lock[`LK_VALLEY])
          n.view = ST_PEAK;
        else if (press[`B_SHIFT] && !lock[`LK_PEAK] && !lock[`LK_VALLEY])
          n.view = ST_VALLEY;
      end
      ST_SP_NUM, ST_SP_VAL:
      begin
        n.tmr = r.tmr + 32'h1;
        if (r.view == ST_SP_NUM && r.tmr >= NUM_SHOW_CYCLES - 32'h1)
          n.view = ST_SP_VAL;
        if (press[`B_RESET])
          n.view = ST_RUN;
        else if (press[`B_SETPT] || r.tmr == SP_TIMEOUT_CYCLES - 32'h1)
        begin
          if (press[`B_SETPT])
          begin
            n.shd[`R_SP0 + r.idx][15:0] = r.edit;
            n.act[`R_SP0 + r.idx][15:0] = r.edit;
          end
          n.view = (r.idx == `LAST_SP) ? ST_RUN : ST_SP_NUM;
          n.idx = r.idx + 2'h1;
          n.tmr = 32'h0;
          n.dig = `LEFT_DIGIT;
          n.edit = r.act[`R_SP0 + r.idx + 2'h1][15:0];
        end
        else if (press[`B_SHIFT])
        begin
          n.dig = r.dig - 2'h1;
          n.tmr = 32'h0;
        end
        else if (press[`B_INC])
        begin
          n.edit[4*r.dig +: 4] = r.edit[4*r.dig +: 4] + 4'h1;
          n.tmr = 32'h0;
        end
      end
      ST_PEAK, ST_VALLEY:
      begin
        if (press[`B_RESET])
        begin
          n.view = ST_RUN;
          n.newper = 1'b1;
        end
        else if (press[`B_SETPT] || press[`B_MENU])
          n.view = ST_RUN;
      end
    endcase

    // Registered outputs
    n.spact = cur_act;
    n.flash = (r.view == ST_PEAK) || (r.view == ST_VALLEY) || (r.view == ST_SP_NUM) || flash_hit;
    unique case (r.view)
      ST_RUN: n.dval = RDG_RAW;
      ST_SP_NUM: n.dval = {14'h0, r.idx} + 16'h1;
      ST_SP_VAL: n.dval = r.edit;
      ST_PEAK: n.dval = r.peak;
      ST_VALLEY: n.dval = r.valley;
    endcase
    n.aen = r.act[`R_CTRL][`CTRL_EN] && !r.shd[`R_CTRL][`CTRL_EDIT];
    n.acode = n.aen ? amap.code : 16'h0000;
    n.vcal = n.aen && !r.act[`R_CTRL][`CTRL_TYPE];
    n.ccal = n.aen && r.act[`R_CTRL][`CTRL_TYPE];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; a power-up period starts fresh
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r <= '0;
      r.newper <= 1'b1;
    end
    else
      r <= n;
  end

  assign AWREADY = r.awready;
  assign WREADY = r.wready;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = r.arready;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  assign DISP_VALUE = r.dval;
  assign DISP_MODE = r.view;
  assign DISP_DIGIT = r.dig;
  assign DISP_FLASH = r.flash;
  assign SP_ACTIVE = r.spact;
  assign ANALOG_CODE = r.acode;
  assign ANALOG_EN = r.aen;
  assign VOLT_CAL = r.vcal;
  assign CURR_CAL = r.ccal;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence sp_enter;
    r.view == ST_RUN && press[`B_SETPT];
  endsequence
  sequence sp_quit;
    in_sp && press[`B_RESET] && !store_now;
  endsequence
  sequence sp_keep;
    in_sp && press[`B_SETPT] && !press[`B_RESET];
  endsequence

  a_deadband_hold: assert property (RDG_VALID && r.alarm[0] && !clr[0] |=> r.alarm[0])
    else $error("alarm dropped inside deadband");
  a_delay_fire: assert property (RDG_VALID && !r.alarm[1] && ovr[1] && r.acnt[1] >= r.act[`R_ADLY][`ADLY_2]
    |=> r.alarm[1])
    else $error("alarm late after delay count");
  a_flash_any: assert property (fsel == `FL_ANY && |cur_act |=> DISP_FLASH)
    else $error("flash missing for active setpoint");
  a_flash_off: assert property (fsel == `FL_NONE && r.view == ST_RUN |=> !DISP_FLASH)
    else $error("flash while disabled");
  a_store_commit: assert property (store_now |=> r.act == r.shd && r.view == ST_RUN)
    else $error("store did not commit");
  a_sp_start: assert property (sp_enter |=> r.view == ST_SP_NUM && r.idx == 2'h0 && r.dig == `LEFT_DIGIT)
    else $error("setpoint view start wrong");
  a_edit_restart: assert property (in_sp && press[`B_SHIFT] && !press[`B_RESET] && !press[`B_SETPT]
    && r.tmr != SP_TIMEOUT_CYCLES - 32'h1 |=> r.tmr == 32'h0)
    else $error("interval not restarted");
  a_edit_discard: assert property (sp_quit |=> r.view == ST_RUN && $stable(r.act[7:4]))
    else $error("abandoned edit stored");
  a_sp_store: assert property (sp_keep |=> r.act[`R_SP0 + $past(r.idx)][15:0] == $past(r.edit))
    else $error("setpoint not stored");
  a_peak_track: assert property (RDG_VALID && !r.newper && RDG_RAW > r.peak |=> r.peak == $past(RDG_RAW))
    else $error("peak not replaced");
  a_view_lock: assert property (r.view == ST_RUN && press[`B_INC] && lock[`LK_PEAK] |=> r.view != ST_PEAK)
    else $error("locked peak view opened");
  a_new_period: assert property (RDG_VALID && r.newper |=> r.peak == r.valley && r.peak == $past(RDG_RAW))
    else $error("period not seeded");
  a_one_cal: assert property (!(VOLT_CAL && CURR_CAL))
    else $error("both outputs calibrated");
  a_out_zero: assert property (!r.act[`R_CTRL][`CTRL_EN] |=> ANALOG_CODE == 16'h0000 && !ANALOG_EN)
    else $error("output active while disabled");
endmodule
`default_nettype wire

// file: meter_operator.sv
/*
  Operator model: presses the front-panel buttons of the meter.
  Assumes the meter syncs the pins to clk and wants a low gap between presses.
*/
`timescale 1ns/1ps
`default_nettype none
module meter_operator
(
  input wire logic clk,
  output logic [4:0] btn
);
  // Released buttons rest low on their pull-downs
  initial btn = 5'h00;
  // Held past the two-stage sync so the press is never missed
  task automatic press(input int b);
    @(posedge clk);
    btn[b] <= 1'b1;
    repeat (3) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: test_alarm_peak_valley_output_config.sv
/*
  Bench for meter_post: register bus, readings, buttons and outputs.
  Assumes meter_operator drives the button pins.
*/
`timescale 1ns/1ps
`default_nettype none
module test_alarm_peak_valley_output_config
  import meter_pkg::*;
;
  logic clk, rst, awv, wv, bready, arv, rready, rv;
  logic awrdy, wrdy, bv, arrdy, rvl, dflash, aen, vcal, ccal;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r, ddig;
  logic signed [15:0] raw, filt;
  logic [15:0] dval, acode;
  logic [4:0] btn;
  logic [3:0] wstrb;
  logic [3:0] spact;
  logic [2:0] dmode;
  int err_total, n_checks;
  ////////////////////////////////////////////////////////////////
  // Short view times keep the run brief
  meter_post #(.SP_TIMEOUT_CYCLES(32'd200), .NUM_SHOW_CYCLES(32'd20)) DUT (
    .CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awv), .AWREADY(awrdy),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wv), .WREADY(wrdy), .BRESP(bresp),
    .BVALID(bv), .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arrdy),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvl), .RREADY(rready), .RDG_RAW(raw),
    .RDG_FILT(filt), .RDG_VALID(rv), .BTN_SETPT(btn[0]), .BTN_SHIFT(btn[1]),
    .BTN_INC(btn[2]), .BTN_RESET(btn[3]), .BTN_MENU(btn[4]), .DISP_VALUE(dval),
    .DISP_MODE(dmode), .DISP_DIGIT(ddig), .DISP_FLASH(dflash), .SP_ACTIVE(spact),
    .ANALOG_CODE(acode), .ANALOG_EN(aen), .VOLT_CAL(vcal), .CURR_CAL(ccal));
  meter_operator op (.clk(clk), .btn(btn));
  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write one word; both channels offered together, each released once taken
  task automatic wr(input logic [5:0] i, input logic [31:0] v);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Read one word
  task automatic rd(input logic [5:0] i);
    @(posedge clk);
    araddr <= {i, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
    end while (rvl !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // One reading; filtered value is half the raw so the two are told apart
  task automatic rdg(input logic signed [15:0] v);
    @(posedge clk);
    raw <= v;
    filt <= v >>> 1;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Peak and valley tracking and views
  task automatic t_peak;
    rdg(100);
    rdg(300);
    rdg(-50);
    rd(17);
    chk("peak", d, 32'h12C);
    rd(18);
    chk("valley", d, 32'hFFFFFFCE);
    op.press(2);
    chk("peak view", dmode, 32'h3);
    chk("peak flash", dflash, 32'h1);
    rdg(500);
    chk("peak live", dval, 32'h1F4);
    repeat (300) @(posedge clk);
    chk("no timeout", dmode, 32'h3);
    op.press(4);
    chk("menu exit", dmode, 32'h0);
    rd(17);
    chk("peak kept", d, 32'h1F4);
    op.press(1);
    chk("valley view", dmode, 32'h4);
    chk("valley shown", dval, 32'hFFCE);
    op.press(3);
    rdg(7);
    rd(17);
    chk("new peak", d, 32'h7);
    rd(18);
    chk("new valley", d, 32'h7);
  endtask
  // Unmapped read and read-only write
  task automatic t_bus;
    rd(6'h20);
    chk("unmapped resp", r, 32'h2);
    chk("unmapped data", d, 32'h0);
    wr(6'h10, 32'h1);
    chk("ro resp", r, 32'h2);
    // Only the low byte lane lands; the other lanes keep the old word
    wstrb <= 4'h1;
    wr(6'h09, 32'h5A5A);
    wstrb <= 4'hF;
    rd(9);
    chk("strobe merge", d, 32'h5A);
  endtask
  // Configuration, commit, mapping and source select
  task automatic t_cfg;
    for (int i = 8; i < 16; i++)
      // Current zero trim of 5 tells the two trim pairs apart
      wr(6'(i), (i == 10 || i == 11) ? 32'h3E8 : (i == 14) ? 32'h5 : 32'h0);
    wr(6'h02, 32'h200);
    wr(6'h03, 32'hA);
    wr(6'h04, 32'h123);
    wr(6'h06, 32'h64);
    wr(6'h07, 32'h64);
    wr(6'h00, 32'h139);
    chk("out en", aen, 32'h1);
    chk("volt cal", {vcal, ccal}, 32'h2);
    rdg(300);
    chk("code filt", acode, 32'h96);
    wr(6'h00, 32'h3B);
    chk("curr cal", {vcal, ccal}, 32'h1);
    rdg(300);
    chk("code raw", acode, 32'h131);
    wr(6'h00, 32'h7);
    chk("edit zero", acode, 32'h0);
    wr(6'h00, 32'h3A);
    chk("out off", aen, 32'h0);
  endtask
  // Alarm delay, deadband and every flash selection
  task automatic t_alarm;
    rdg(50);
    rdg(101);
    chk("al1 at once", spact[2], 32'h1);
    chk("al2 delayed", spact[3], 32'h0);
    rdg(101);
    rdg(101);
    chk("al2 third", spact[3], 32'h1);
    // Reading 101 is under setpoint 1 and over setpoint 2
    chk("sp active", spact, 32'hE);
    for (int s = 0; s < 6; s++)
    begin
      wr(6'h00, 32'(s << 4) | 32'h8);
      chk("flash sel", dflash, 32'((6'h3C >> s) & 6'h01));
    end
    rdg(95);
    chk("deadband hold", spact[2], 32'h1);
    rdg(89);
    chk("deadband clear", spact[2], 32'h0);
    chk("flash any on", dflash, 32'h1);
    // Below setpoint 2 as well, so nothing is active
    rdg(-5);
    chk("flash any off", dflash, 32'h0);
  endtask
  // Setpoint view, edit, store and abandon
  task automatic t_setpt;
    op.press(0);
    chk("sp number", {dmode, dval}, 32'h10001);
    repeat (25) @(posedge clk);
    chk("sp value", {ddig, dmode, dval}, 32'h1A0123);
    op.press(2);
    chk("sp inc", dval, 32'h1123);
    op.press(0);
    rd(4);
    chk("sp stored", d, 32'h1123);
    op.press(3);
    chk("sp exit", dmode, 32'h0);
    op.press(0);
    repeat (25) @(posedge clk);
    op.press(2);
    repeat (1100) @(posedge clk);
    chk("sp timeout", dmode, 32'h0);
    rd(4);
    chk("sp kept", d, 32'h1123);
  endtask
  // Lockout bits
  task automatic t_lock;
    wr(6'h01, 32'hC);
    wr(6'h0A, 32'h7D0);
    rd(10);
    chk("point locked", d, 32'h3E8);
    wr(6'h00, 32'h52);
    rd(0);
    chk("type locked", d, 32'h50);
    wr(6'h01, 32'h1);
    op.press(2);
    chk("view locked", dmode, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    {rst, awv, wv, bready, arv, rready, rv} = 7'h40;
    {awaddr, araddr, wdata, raw, filt} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_peak();
    t_bus();
    t_cfg();
    t_alarm();
    t_setpt();
    t_lock();
    summarize();
  end
  // Watchdog, well past the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
